// ---- pgm_pins.sv ----
// Board model of the P2/P3 pins: each pin follows its driver or the
// external level set by the bench; no pull, so undriven shows ext only.
`timescale 1ns/10ps
module pgm_pins (
  input wire logic [3:0] p2_out,
  input wire logic [3:0] p2_oe,
  input wire logic [3:0] p3_out,
  input wire logic [3:0] p3_oe,
  input wire logic [3:0] ext2,
  input wire logic [3:0] ext3,
  output logic [3:0] p2_in,
  output logic [3:0] p3_in
);
  // Driven pins read back their own value
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & ext2);
  assign p3_in = (p3_oe & p3_out) | (~p3_oe & ext3);
endmodule : pgm_pins

// ---- pgm_pkg.sv ----
// Shared constants for the P2/P3 port group pin controller.
// Assumes a Wishbone slave with byte addresses equal to four times the
// register index, 8-bit registers sitting in data lane 0.
package pgm_pkg;

  // Bus geometry
  localparam int ADR_W = 16;               // Byte address width
  localparam int DAT_W = 32;               // Wishbone data width
  localparam int IDX_W = 14;               // Register index width
  localparam int REG_W = 8;                // Register width

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] P2_OUTPUT_DISABLE_IDX = 14'h28b0;
  localparam logic [IDX_W-1:0] P2_INPUT_ENABLE_IDX = 14'h28b1;
  localparam logic [IDX_W-1:0] P2_OUTPUT_VALUE_IDX = 14'h28b2;
  localparam logic [IDX_W-1:0] P2_PIN_LEVEL_IDX = 14'h28b3;
  localparam logic [IDX_W-1:0] P3_OUTPUT_DISABLE_IDX = 14'h28b4;
  localparam logic [IDX_W-1:0] P3_INPUT_ENABLE_IDX = 14'h28b5;
  localparam logic [IDX_W-1:0] P3_OUTPUT_VALUE_IDX = 14'h28b6;
  localparam logic [IDX_W-1:0] P3_PIN_LEVEL_IDX = 14'h28b7;
  localparam logic [IDX_W-1:0] P2_BIT0_FUNCTION_IDX = 14'h28c9;
  localparam logic [IDX_W-1:0] P2_BIT1_FUNCTION_IDX = 14'h28ca;
  localparam logic [IDX_W-1:0] P2_BIT4_FUNCTION_IDX = 14'h28cd;
  localparam logic [IDX_W-1:0] P2_BIT5_FUNCTION_IDX = 14'h28ce;
  localparam logic [IDX_W-1:0] IR_CARRIER_CTRL_IDX = 14'h28d0;
  localparam logic [IDX_W-1:0] POWER_CONTROL_ZERO_IDX = 14'h2d00;

  // Field positions
  localparam int PORT_POWER_GATE_BIT = 3;  // Gate bit in power control
  localparam int IR_CARRIER_EN_BIT = 0;    // Carrier enable bit

  // Function select codes
  localparam logic [1:0] FS_GPIO = 2'h0;
  localparam logic [1:0] FS_CODE_01 = 2'h1;
  localparam logic [1:0] FS_CODE_10 = 2'h2;
  localparam logic [1:0] FS_CODE_11 = 2'h3;

  // Reset values (four implemented pins per group)
  localparam logic [3:0] OUTPUT_DISABLE_RST = 4'hf;
  localparam logic [3:0] INPUT_ENABLE_RST = 4'h0;
  localparam logic [3:0] OUTPUT_VALUE_RST = 4'hf;
  localparam logic [3:0] PIN_LEVEL_RST = 4'h0;
  localparam logic [1:0] FUNCTION_RST = 2'h0;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

endpackage : pgm_pkg

// ---- pgm_sync.sv ----
// Three-stage pin input synchroniser with agreement filter.
// Assumes inputs are asynchronous to mclk; output is registered.
`timescale 1ns/10ps
module pgm_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import pgm_pkg::*;

  logic [WIDTH-1:0] stage1; // Metastable catcher, read only by stage2
  logic [WIDTH-1:0] stage2; // Second stage
  logic [WIDTH-1:0] stage3; // Third stage
  logic [WIDTH-1:0] next_out; // Accept a change once stages 2 and 3 agree

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_agree
      assign next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
    end
  endgenerate

  // Shift chain and filtered output
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_out;
    end
  end

endmodule : pgm_sync

// ---- pgm_top.sv ----
// Pin control for port groups P2 and P3 with Wishbone register access.
// Assumes pins resolved outside from out/oe; LCD and peripherals nearby.
// Function
// [R1] Input enable bits gate sampling, reset zero
// [R2] Output enable inverted; P3 bits reset one
// [R3] Enabled input shows live pin, any function
// [R4] Software disables unused inputs to save power
// [R5] P2 bit0 select: gpio, osc, rx4, t2
// [R6] P2 bit1 select: gpio, reserved, tx4, t0
// [R7] P2 bit4 select: gpio or rx2
// [R8] P2 bit5 select: gpio or tx2, carrier
// [R9] P3 pins shared with LCD backplanes
// [R10] Backplane pins: software disables output, input
// [R11] LCD driver off makes P3 pins gpio
// [R12] Power gate bit gates port control logic
// [R13] P2 output value bits reset one
// [R14] P3 output value four bits reset one
// [R15] Power gate leaves special functions working
// [R16] P2 output disable bits reset one
// [R17] Gpio drives value when enabled, else off
`timescale 1ns/10ps
module pgm_top (
  input wire logic mclk,
  input wire logic srst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pgm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pgm_pkg::DAT_W-1:0] wb_dat_i,
  output logic [pgm_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // P2 pins, index 0..3 = port bits 0,1,4,5
  input wire logic [3:0] p2_in,
  output logic [3:0] p2_out,
  output logic [3:0] p2_oe,
  // P3 pins
  input wire logic [3:0] p3_in,
  output logic [3:0] p3_out,
  output logic [3:0] p3_oe,
  // LCD driver side
  input wire logic lcd_drv_en,
  input wire logic [3:0] lcd_backplane,
  // Peripheral side
  input wire logic oscillator_waveform_out,
  input wire logic serial_four_transmit,
  input wire logic serial_two_transmit,
  input wire logic ir_carrier_38k,
  output logic serial_four_receive,
  output logic serial_two_receive,
  output logic timer_two_ext_input,
  output logic timer_zero_ext_input,
  output logic port_power_gate_o
);
  import pgm_pkg::*;

  // Software-visible state
  logic [3:0] p2_output_disable; // One disables the driver
  logic [3:0] p2_input_enable; // One enables sampling
  logic [3:0] p2_output_value; // Gpio drive data
  logic [3:0] p2_pin_level; // Captured pin levels
  logic [3:0] p3_output_disable;
  logic [3:0] p3_input_enable;
  logic [3:0] p3_output_value;
  logic [3:0] p3_pin_level;
  logic [1:0] fsel [4]; // Function selects for P2 bits 0,1,4,5
  logic port_power_gate; // Power control bit 3
  logic ir_carrier_en; // Turns tx2 into an IR carrier burst

  // Synchronised pins
  logic [7:0] pins_s;
  logic [3:0] p2_s;
  logic [3:0] p3_s;

  // Bus decode
  logic [IDX_W-1:0] idx;
  logic bus_req;
  logic wr_en;
  logic [REG_W-1:0] wdat;
  logic [REG_W-1:0] rd_byte;

  // Next values of registered outputs
  logic [3:0] next_p2_oe;
  logic [3:0] next_p2_out;
  logic [3:0] next_p3_oe;
  logic [3:0] next_p3_out;
  logic [3:0] sf_drive; // Pin driven by a special output
  logic [3:0] sf_val; // Special output value
  logic [3:0] gpio_mode; // Pin under gpio control
  logic tx2_line; // Tx2 after optional carrier

  // Map four P2 pins onto their register bit positions 0,1,4,5
  function automatic logic [7:0] p2_pack(input logic [3:0] v);
    p2_pack = {2'h0, v[3], v[2], 2'h0, v[1], v[0]};
  endfunction : p2_pack

  function automatic logic [3:0] p2_unpack(input logic [7:0] v);
    p2_unpack = {v[5], v[4], v[1], v[0]};
  endfunction : p2_unpack

  // True when the select routes a peripheral input from the pin
  function automatic logic sf_is_input(input int pin, input logic [1:0] c);
    case (pin)
      0: sf_is_input = (c == FS_CODE_10) || (c == FS_CODE_11);
      1: sf_is_input = (c == FS_CODE_11);
      2: sf_is_input = (c == FS_CODE_10);
      default: sf_is_input = 1'b0;
    endcase
  endfunction : sf_is_input

  // Pin inputs come from outside the clock domain
  pgm_sync #(.WIDTH(8)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({p3_in, p2_in}),
    .sync_out(pins_s)
  );

  assign p2_s = pins_s[3:0];
  assign p3_s = pins_s[7:4];

  // Byte address is four times the index; only lane 0 carries data
  assign idx = wb_adr_i[ADR_W-1:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr_en = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wdat = wb_dat_i[REG_W-1:0];

  // Read mux; reserved bits and unmapped addresses read zero
  assign rd_byte =
    (idx == P2_OUTPUT_DISABLE_IDX) ? p2_pack(p2_output_disable) :
    (idx == P2_INPUT_ENABLE_IDX) ? p2_pack(p2_input_enable) :
    (idx == P2_OUTPUT_VALUE_IDX) ? p2_pack(p2_output_value) :
    (idx == P2_PIN_LEVEL_IDX) ? p2_pack(p2_pin_level) :
    (idx == P3_OUTPUT_DISABLE_IDX) ? {4'h0, p3_output_disable} :
    (idx == P3_INPUT_ENABLE_IDX) ? {4'h0, p3_input_enable} :
    (idx == P3_OUTPUT_VALUE_IDX) ? {4'h0, p3_output_value} :
    (idx == P3_PIN_LEVEL_IDX) ? {4'h0, p3_pin_level} :
    (idx == P2_BIT0_FUNCTION_IDX) ? {6'h00, fsel[0]} : // [R5]
    (idx == P2_BIT1_FUNCTION_IDX) ? {6'h00, fsel[1]} :
    (idx == P2_BIT4_FUNCTION_IDX) ? {6'h00, fsel[2]} :
    (idx == P2_BIT5_FUNCTION_IDX) ? {6'h00, fsel[3]} :
    (idx == IR_CARRIER_CTRL_IDX) ? {7'h00, ir_carrier_en} :
    (idx == POWER_CONTROL_ZERO_IDX) ? {4'h0, port_power_gate, 3'h0} :
    8'h00;

  // Special output drivers per P2 pin
  assign sf_drive[0] = (fsel[0] == FS_CODE_01); // [R5]
  assign sf_drive[1] = (fsel[1] == FS_CODE_10); // [R6]
  assign sf_drive[2] = 1'b0; // [R7]
  assign sf_drive[3] = (fsel[3] == FS_CODE_10); // [R8]
  // Carrier on while the serial line is low, as IR links expect
  assign tx2_line = ir_carrier_en ? (~serial_two_transmit & ir_carrier_38k)
                                  : serial_two_transmit; // [R8]
  assign sf_val[0] = oscillator_waveform_out;
  assign sf_val[1] = serial_four_transmit;
  assign sf_val[2] = 1'b0;
  assign sf_val[3] = tx2_line;

  // Driver control: special outputs ignore the gate, gpio does not
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_p2
      // Reserved and unlisted codes fall back to gpio
      assign gpio_mode[i] = ~sf_drive[i] & ~sf_is_input(i, fsel[i]);
      assign next_p2_oe[i] = sf_drive[i] | // [R15]
        (gpio_mode[i] & ~port_power_gate & ~p2_output_disable[i]); // [R2] [R17] [R12]
      assign next_p2_out[i] = sf_drive[i] ? sf_val[i]
                                          : p2_output_value[i]; // [R17]
    end
    for (i = 0; i < 4; i++) begin : g_p3
      // LCD driver owns the pin while it is on
      assign next_p3_oe[i] = lcd_drv_en ? 1'b1 : // [R9] [R11]
        (~port_power_gate & ~p3_output_disable[i]); // [R2] [R12] [R17]
      assign next_p3_out[i] = lcd_drv_en ? lcd_backplane[i]
                                         : p3_output_value[i]; // [R9]
    end
  endgenerate

  // Bus answer: one-cycle ack, registered read data
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // P2 control registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      p2_output_disable <= OUTPUT_DISABLE_RST; // [R16]
      p2_input_enable <= INPUT_ENABLE_RST; // [R1]
      p2_output_value <= OUTPUT_VALUE_RST; // [R13]
    end else if (wr_en) begin
      if (idx == P2_OUTPUT_DISABLE_IDX) begin
        p2_output_disable <= p2_unpack(wdat);
      end
      if (idx == P2_INPUT_ENABLE_IDX) begin
        p2_input_enable <= p2_unpack(wdat);
      end
      if (idx == P2_OUTPUT_VALUE_IDX) begin
        p2_output_value <= p2_unpack(wdat);
      end
    end
  end

  // P3 control registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      p3_output_disable <= OUTPUT_DISABLE_RST; // [R2]
      p3_input_enable <= INPUT_ENABLE_RST; // [R1]
      p3_output_value <= OUTPUT_VALUE_RST; // [R14]
    end else if (wr_en) begin
      if (idx == P3_OUTPUT_DISABLE_IDX) begin
        p3_output_disable <= wdat[3:0];
      end
      if (idx == P3_INPUT_ENABLE_IDX) begin
        p3_input_enable <= wdat[3:0];
      end
      if (idx == P3_OUTPUT_VALUE_IDX) begin
        p3_output_value <= wdat[3:0];
      end
    end
  end

  // Function selects; only the two low bits are stored
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int k = 0; k < 4; k++) begin
        fsel[k] <= FUNCTION_RST; // [R6] [R7]
      end
    end else if (wr_en) begin
      if (idx == P2_BIT0_FUNCTION_IDX) begin
        fsel[0] <= wdat[1:0]; // [R5]
      end
      if (idx == P2_BIT1_FUNCTION_IDX) begin
        fsel[1] <= wdat[1:0]; // [R6]
      end
      if (idx == P2_BIT4_FUNCTION_IDX) begin
        fsel[2] <= wdat[1:0]; // [R7]
      end
      if (idx == P2_BIT5_FUNCTION_IDX) begin
        fsel[3] <= wdat[1:0]; // [R8]
      end
    end
  end

  // Power gate and carrier control
  always_ff @(posedge mclk) begin
    if (srst) begin
      port_power_gate <= 1'b0;
      ir_carrier_en <= 1'b0;
    end else if (wr_en) begin
      if (idx == POWER_CONTROL_ZERO_IDX) begin
        port_power_gate <= wdat[PORT_POWER_GATE_BIT]; // [R12]
      end
      if (idx == IR_CARRIER_CTRL_IDX) begin
        ir_carrier_en <= wdat[IR_CARRIER_EN_BIT]; // [R8]
      end
    end
  end

  // Pin level capture; disabled or gated bits hold, saving toggles
  always_ff @(posedge mclk) begin
    if (srst) begin
      p2_pin_level <= PIN_LEVEL_RST;
      p3_pin_level <= PIN_LEVEL_RST;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (p2_input_enable[k] & ~port_power_gate) begin
          p2_pin_level[k] <= p2_s[k]; // [R1] [R3] [R4]
        end
        if (p3_input_enable[k] & ~port_power_gate) begin
          p3_pin_level[k] <= p3_s[k]; // [R1] [R10]
        end
      end
    end
  end

  // Pin drivers, registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      p2_oe <= 4'h0;
      p2_out <= OUTPUT_VALUE_RST;
      p3_oe <= 4'h0;
      p3_out <= OUTPUT_VALUE_RST;
    end else begin
      p2_oe <= next_p2_oe;
      p2_out <= next_p2_out;
      p3_oe <= next_p3_oe;
      p3_out <= next_p3_out;
    end
  end

  // Peripheral inputs; serial idles high, timers idle low
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_four_receive <= 1'b1;
      serial_two_receive <= 1'b1;
      timer_two_ext_input <= 1'b0;
      timer_zero_ext_input <= 1'b0;
      port_power_gate_o <= 1'b0;
    end else begin
      serial_four_receive <= (fsel[0] == FS_CODE_10) ? p2_s[0] : 1'b1; // [R5]
      timer_two_ext_input <= (fsel[0] == FS_CODE_11) & p2_s[0]; // [R5]
      timer_zero_ext_input <= (fsel[1] == FS_CODE_11) & p2_s[1]; // [R6]
      serial_two_receive <= (fsel[2] == FS_CODE_10) ? p2_s[2] : 1'b1; // [R7]
      port_power_gate_o <= port_power_gate;
    end
  end

endmodule : pgm_top

// ---- pgm_top_checker.sv ----
// Port-level assertions for the P2/P3 pin controller.
// Assumes binding to pgm_top; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module pgm_top_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [pgm_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] p2_out,
  input wire logic [3:0] p2_oe,
  input wire logic [3:0] p3_out,
  input wire logic [3:0] p3_oe,
  input wire logic lcd_drv_en,
  input wire logic serial_four_receive,
  input wire logic serial_two_receive,
  input wire logic timer_two_ext_input,
  input wire logic timer_zero_ext_input,
  input wire logic port_power_gate_o
);
  import pgm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  // Bus answer: exactly one cycle after the request, one cycle wide
  a_ack_single: assert property (disable iff (srst)
    wb_ack_o |=> !wb_ack_o) else $error("ack wider than one cycle");
  a_ack_prompt: assert property (disable iff (srst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (disable iff (srst)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_zero: assert property (disable iff (srst)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  // Reset checks carry no disable, since srst is their cause
  a_reset_drivers: assert property (
    srst |=> p2_oe == 4'h0 && p3_oe == 4'h0 && p2_out == 4'hf
    && p3_out == 4'hf) else $error("pin drivers wrong after reset");
  a_reset_periph: assert property (
    srst |=> serial_four_receive && serial_two_receive
    && !timer_two_ext_input && !timer_zero_ext_input
    && !port_power_gate_o) else $error("peripheral side wrong at reset");
  a_lcd_owns: assert property (disable iff (srst)
    lcd_drv_en [*2] |-> p3_oe == 4'hf) else $error("lcd not driving");
  a_gate_p3_off: assert property (disable iff (srst)
    (port_power_gate_o && !lcd_drv_en) [*2] |-> p3_oe == 4'h0)
    else $error("gated P3 still driving");
  // P2 output enables only move after a bus access has been answered
  a_oe_after_write: assert property (disable iff (srst)
    !$stable(p2_oe) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("P2 driver changed without a write");
  c_access: cover property (wb_cyc_i && wb_ack_o);
  c_lcd: cover property (lcd_drv_en && p3_oe == 4'hf);
  c_gate: cover property (port_power_gate_o);
endmodule : pgm_top_checker

// ---- pgm_top_tb.sv ----
// Self-checking bench for the P2/P3 pin controller.
// Assumes pgm_pkg, pgm_top, pgm_pins and the checker are compiled first.
`timescale 1ns/10ps
module pgm_top_tb;
  import pgm_pkg::*;
  logic mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0, lcd = 0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0, rdat, dat_o;
  logic ack, rx4, rx2, tm2, tm0, gate;
  logic [3:0] p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe;
  logic [3:0] ext2 = 4'ha, ext3 = 4'h6, bp = 4'h5;
  // Peripheral levels chosen to differ from the gpio values
  logic osc = 0, tx4 = 1, tx2 = 0;
  // Stand-in for the infrared carrier that the serial two output can carry
  logic car = 0;
  int failures = 0, n_tests = 0;
  pgm_top i_pgm_top (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .p2_in(p2_in),
    .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in), .p3_out(p3_out),
    .p3_oe(p3_oe), .lcd_drv_en(lcd), .lcd_backplane(bp),
    .oscillator_waveform_out(osc), .serial_four_transmit(tx4),
    .serial_two_transmit(tx2), .ir_carrier_38k(car),
    .serial_four_receive(rx4), .serial_two_receive(rx2),
    .timer_two_ext_input(tm2), .timer_zero_ext_input(tm0),
    .port_power_gate_o(gate));
  pgm_pins i_pgm_pins (.p2_out(p2_out), .p2_oe(p2_oe), .p3_out(p3_out),
    .p3_oe(p3_oe), .ext2(ext2), .ext3(ext3), .p2_in(p2_in),
    .p3_in(p3_in));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic conclude;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Classic single cycle; request held until ack is sampled high.
  // No local limit: a slave that never answers is caught by the watchdog.
  task automatic wb(input logic w, input logic [IDX_W-1:0] idx,
    input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(rdat, {24'h0, e});
  endtask : rd
  task automatic t_reset;
    rd(P2_OUTPUT_DISABLE_IDX, 8'h33);
    rd(P2_INPUT_ENABLE_IDX, 8'h00);
    rd(P2_OUTPUT_VALUE_IDX, 8'h33);
    rd(P3_OUTPUT_DISABLE_IDX, 8'h0f);
    rd(P3_INPUT_ENABLE_IDX, 8'h00);
    rd(P3_OUTPUT_VALUE_IDX, 8'h0f);
    rd(P3_PIN_LEVEL_IDX, 8'h00);
    rd(P2_BIT1_FUNCTION_IDX, 8'h00);
    rd(P2_BIT4_FUNCTION_IDX, 8'h00);
    rd(14'h28c0, 8'h00); // Unmapped place reads zero
  endtask : t_reset
  task automatic t_gpio;
    wb(1'b1, P2_OUTPUT_VALUE_IDX, 8'h21);
    wb(1'b1, P2_OUTPUT_DISABLE_IDX, 8'h10);
    wb(1'b1, P3_OUTPUT_VALUE_IDX, 8'h0a);
    wb(1'b1, P3_OUTPUT_DISABLE_IDX, 8'h00);
    wb(1'b1, P2_BIT0_FUNCTION_IDX, 8'hfc);
    rd(P2_BIT0_FUNCTION_IDX, 8'h00);
    chk(p2_oe, 4'hb);
    chk(p2_out & p2_oe, 4'h9);
    chk({p3_oe, p3_out}, 8'hfa);
  endtask : t_gpio
  task automatic t_input;
    tick(8);
    rd(P2_PIN_LEVEL_IDX, 8'h00);
    wb(1'b1, P2_INPUT_ENABLE_IDX, 8'h33);
    wb(1'b1, P3_INPUT_ENABLE_IDX, 8'h0f);
    tick(8);
    rd(P2_PIN_LEVEL_IDX, 8'h21);
    rd(P3_PIN_LEVEL_IDX, 8'h0a);
    // Bit 0 to serial receive: pin released, level still visible
    wb(1'b1, P2_BIT0_FUNCTION_IDX, 8'h02);
    tick(8);
    rd(P2_PIN_LEVEL_IDX, 8'h20);
    chk(rx4, 1'b0);
  endtask : t_input
  task automatic t_func;
    ext2 <= 4'h3;
    wb(1'b1, P2_BIT0_FUNCTION_IDX, 8'h03);
    wb(1'b1, P2_BIT1_FUNCTION_IDX, 8'h03);
    wb(1'b1, P2_BIT4_FUNCTION_IDX, 8'h02);
    tick(8);
    chk({tm2, tm0, rx2}, 3'b110);
    chk(p2_oe, 4'h8);
    wb(1'b1, P2_BIT0_FUNCTION_IDX, 8'h01);
    wb(1'b1, P2_BIT1_FUNCTION_IDX, 8'h02);
    wb(1'b1, P2_BIT5_FUNCTION_IDX, 8'h02);
    // Gate after the special functions are set: they must survive
    wb(1'b1, POWER_CONTROL_ZERO_IDX, 8'h08);
    tick(8);
    chk(p2_oe, 4'hb);
    chk(p2_out & 4'hb, 4'h2);
    chk({gate, p3_oe}, 5'h10);
    rd(P3_PIN_LEVEL_IDX, 8'h0a);
    wb(1'b1, POWER_CONTROL_ZERO_IDX, 8'h00);
  endtask : t_func
  task automatic t_lcd;
    wb(1'b1, P3_INPUT_ENABLE_IDX, 8'h00);
    wb(1'b1, P3_OUTPUT_DISABLE_IDX, 8'h0f);
    lcd <= 1'b1;
    tick(3);
    chk({p3_oe, p3_out}, {4'hf, bp});
    lcd <= 1'b0;
    wb(1'b1, P2_INPUT_ENABLE_IDX, 8'h00);
  endtask : t_lcd
  // Bit 5 still carries serial two transmit; carrier burst while line low
  task automatic t_carrier;
    wb(1'b1, IR_CARRIER_CTRL_IDX, 8'h01);
    rd(IR_CARRIER_CTRL_IDX, 8'h01);
    car <= 1'b1;
    tick(3);
    chk(p2_out[3], 1'b1);
    tx2 <= 1'b1;
    tick(3);
    chk(p2_out[3], 1'b0);
    wb(1'b1, IR_CARRIER_CTRL_IDX, 8'h00);
    tick(3);
    chk(p2_out[3], 1'b1);
  endtask : t_carrier
  initial begin
    tick(5);
    srst <= 1'b0;
    t_reset();
    t_gpio();
    t_input();
    t_func();
    t_lcd();
    t_carrier();
    conclude();
  end
  // Whole run needs under two hundred cycles
  initial begin
    tick(5000);
    failures++;
    conclude();
  end
endmodule : pgm_top_tb
bind pgm_top pgm_top_checker i_pgm_top_checker (.mclk, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .p2_out, .p2_oe, .p3_out, .p3_oe,
  .lcd_drv_en, .serial_four_receive, .serial_two_receive,
  .timer_two_ext_input, .timer_zero_ext_input, .port_power_gate_o);
